// ### design/rpt_top.sv
// Reset pin, power-drive trip and shared PWM/GPIO pin control.
// Operation
// [RULE1] Low reset pin halts core, program counter zero.
// [RULE2] Reset release starts fetch at address zero.
// [RULE3] Watchdog reset drives pin low 128 cycles.
// [RULE4] Reset pin open-drain, external driver open-drain.
// [RULE5] Trip low raises interrupt, PWM outputs tristate.
// [RULE6] Trip tristate works even when core halted.
// [RULE7] Trip and GPIO functions both active after reset.
// [RULE8] Mask bit zero disables trip for GPIO use.
// [RULE9] Wake needs trip held low long enough.
// [RULE10] Trip held high while boot loader runs.
// [RULE11] Compare outputs share pins with GPIO bits.
// [RULE12] Timer PWM, interrupt one, port B share pin.
// [RULE13] Interrupt two, ADC, capture, GPIO, clock share pin.
// [RULE14] Bit seven routes CPU clock, inputs see one.
// [RULE15] Bit eight selects timer PWM, interrupt unaffected.
// [RULE16] Reset and trip pins synchronised before use.
`default_nettype none
`include "rpt_defines.svh"
module rpt_top (
   input  wire logic                 CLK_SYS,       // 50 MHz system clock.
   input  wire logic                 RSTN,          // Power-on reset, active low.
   input  wire logic                 CE,            // Clock enable, freezes state.
   input  wire logic                 RESET_PIN_N_I, // Reset pin level.
   output var  logic                 RESET_PIN_N_O, // Reset pin drive value.
   output var  logic                 RESET_PIN_OE,  // Reset pin drive enable.
   input  wire logic                 WD_RESET_REQ,  // Watchdog reset request pulse.
   output var  logic                 CORE_HALT,     // Core held in reset.
   output var  logic                 PC_LOAD,       // Load program counter.
   output var  logic [15:0]          PC_VALUE,      // Program counter load value.
   input  wire logic                 TRIP_PIN_N_I,  // Trip pin level.
   input  wire logic [15:0]          IRQ_MASK_REG,  // Event interrupt mask register.
   input  wire logic [15:0]          PIN_CTRL_REG,  // Master pin control register.
   output var  logic                 TRIP_IRQ,      // Trip interrupt pulse.
   input  wire rpt_pkg::rpt_func_type FUNC_IN,      // Peripheral outputs.
   input  wire rpt_pkg::rpt_gpio_type GPIO_IN,      // GPIO data and directions.
   input  wire logic [3:0]           CMP_SEL,       // Compare function per pin.
   input  wire logic [5:0]           PIN_I,         // Shared pin levels.
   output var  logic [5:0]           PIN_O,         // Shared pin drive values.
   output var  logic [5:0]           PIN_OE,        // Shared pin drive enables.
   output var  logic                 EXT_IRQ_1_IN,  // Interrupt one pin view.
   output var  logic                 EXT_IRQ_2_IN,  // Interrupt two pin view.
   output var  logic                 ADC_START_IN,  // ADC start pin view.
   output var  logic                 CAPTURE_IN_1   // Capture pin view.
);
   //////////////////////////////////////////////////////////////////////////////
   // Pin 0..3 compare/gpio_a_bit1..4, pin 4 timer2/gpio_b_bit0, pin 5 clock/gpio_a_bit7.
   typedef struct packed {
      rpt_pkg::rpt_rst_state_type st;
      logic [7:0]                 cnt;
      logic                       halt;
      logic                       pc_load;
      logic                       rst_oe;
      logic                       trip_prev;
      logic                       irq;
      logic [5:0]                 pin_o;
      logic [5:0]                 pin_oe;
      logic                       x1;
      logic                       x2;
   } rpt_state_type;

   rpt_state_type s_q;
   rpt_state_type s_d;
   logic [7:0]    sync_q;
   logic          rst_pin_s;
   logic          trip_s;
   logic [5:0]    pin_s;
   logic          trip_active;

   // Shared pin levels come from outside the clock domain as well, so they share the synchroniser.
   rpt_sync #(.WIDTH(8)) u_sync (
      .clk   (CLK_SYS),
      .rst_n (RSTN),
      .ce    (CE),
      .d     ({RESET_PIN_N_I, TRIP_PIN_N_I, PIN_I}),
      .q     (sync_q)
   ); // RULE16
   assign rst_pin_s = sync_q[7];
   assign trip_s    = sync_q[6];
   assign pin_s     = sync_q[5:0];
   // Trip enabled while mask bit set; reset value has it set.
   assign trip_active = IRQ_MASK_REG[`RPT_TRIP_MASK_BIT] && !trip_s; // RULE8

   //////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d = s_q;
      if (CE) begin
         s_d.pc_load = 1'b0;
         case (s_q.st)
            rpt_pkg::RPT_RUN: begin
               if (WD_RESET_REQ) begin
                  s_d.st     = rpt_pkg::RPT_WD_DRIVE;
                  s_d.cnt    = `RPT_WD_RESET_CYCLES - 8'd1;
                  s_d.rst_oe = 1'b1; // RULE3
               end
            end
            rpt_pkg::RPT_WD_DRIVE: begin
               if (s_q.cnt == 8'd0) begin
                  s_d.st     = rpt_pkg::RPT_RUN;
                  s_d.rst_oe = 1'b0;
               end else begin
                  s_d.cnt = s_q.cnt - 8'd1; // RULE3
               end
            end
            default: begin
               s_d.st = rpt_pkg::RPT_RUN;
            end
         endcase
         s_d.halt = !rst_pin_s || s_d.rst_oe; // RULE1
         if (s_q.halt && !s_d.halt) begin
            s_d.pc_load = 1'b1; // RULE2
         end
         s_d.trip_prev = trip_active;
         s_d.irq = trip_active && !s_q.trip_prev; // RULE5
         for (int i = 0; i < 6; i++) begin
            s_d.pin_o[i]  = GPIO_IN.gpio_o[i];
            s_d.pin_oe[i] = GPIO_IN.gpio_oe[i];
         end
         for (int i = 0; i < 4; i++) begin
            if (CMP_SEL[i]) begin
               s_d.pin_o[i]  = FUNC_IN.cmp_out[i];
               s_d.pin_oe[i] = !trip_active; // RULE5 RULE6 RULE11
            end
         end
         if (PIN_CTRL_REG[`RPT_TIMER2_PWM_OUT_SEL_BIT]) begin
            s_d.pin_o[4]  = FUNC_IN.t2_pwm;
            s_d.pin_oe[4] = !trip_active; // RULE12 RULE15
         end
         if (PIN_CTRL_REG[`RPT_CPU_CLOCK_OUT_SEL_BIT]) begin
            s_d.pin_o[5]  = FUNC_IN.cpu_clk;
            s_d.pin_oe[5] = 1'b1; // RULE13 RULE14
         end
         s_d.x1 = pin_s[4]; // RULE15
         s_d.x2 = PIN_CTRL_REG[`RPT_CPU_CLOCK_OUT_SEL_BIT] ? 1'b1 : pin_s[5]; // RULE14
      end
   end

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         s_q <= '{st: rpt_pkg::RPT_RUN, cnt: 8'h00, halt: 1'b1, pc_load: 1'b0,
                  rst_oe: 1'b0, trip_prev: 1'b0, irq: 1'b0, pin_o: 6'h00,
                  pin_oe: 6'h00, x1: 1'b1, x2: 1'b1}; // RULE7
      end else begin
         s_q <= s_d;
      end
   end

   // Open-drain: only ever drives low.
   assign RESET_PIN_N_O = 1'b0; // RULE4
   assign RESET_PIN_OE  = s_q.rst_oe;
   assign CORE_HALT     = s_q.halt;
   assign PC_LOAD       = s_q.pc_load;
   assign PC_VALUE      = `RPT_RESET_VECTOR; // RULE2
   assign TRIP_IRQ      = s_q.irq;
   assign PIN_O         = s_q.pin_o;
   assign PIN_OE        = s_q.pin_oe;
   assign EXT_IRQ_1_IN  = s_q.x1;
   assign EXT_IRQ_2_IN  = s_q.x2;
   assign ADC_START_IN  = s_q.x2;
   assign CAPTURE_IN_1  = s_q.x2;

   //////////////////////////////////////////////////////////////////////////////
   property p_wd_low;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && WD_RESET_REQ && s_q.st == rpt_pkg::RPT_RUN) |=> RESET_PIN_OE;
   endproperty
   a_wd_low: assert property (p_wd_low) else $error("watchdog drive missing"); // RULE3
   property p_halt;
      @(posedge CLK_SYS) disable iff (!RSTN) (CE && !rst_pin_s) |=> CORE_HALT;
   endproperty
   a_halt: assert property (p_halt) else $error("core not halted"); // RULE1
   property p_pc;
      @(posedge CLK_SYS) disable iff (!RSTN) PC_LOAD |-> !CORE_HALT && $past(CORE_HALT);
   endproperty
   a_pc: assert property (p_pc) else $error("bad pc load"); // RULE2
   property p_trip;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && trip_active && CMP_SEL[0]) |=> !PIN_OE[0];
   endproperty
   a_trip: assert property (p_trip) else $error("pwm not tristated"); // RULE5
   property p_irq;
      @(posedge CLK_SYS) disable iff (!RSTN) TRIP_IRQ |-> $past(trip_active);
   endproperty
   a_irq: assert property (p_irq) else $error("spurious trip irq"); // RULE5
   property p_clk;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && PIN_CTRL_REG[`RPT_CPU_CLOCK_OUT_SEL_BIT]) |=> EXT_IRQ_2_IN && PIN_OE[5];
   endproperty
   a_clk: assert property (p_clk) else $error("clock out view wrong"); // RULE14
   property p_t2;
      @(posedge CLK_SYS) disable iff (!RSTN) CE |=> EXT_IRQ_1_IN == $past(pin_s[4]);
   endproperty
   a_t2: assert property (p_t2) else $error("interrupt one view wrong"); // RULE15
   property p_od;
      @(posedge CLK_SYS) disable iff (!RSTN) RESET_PIN_OE |-> !RESET_PIN_N_O;
   endproperty
   a_od: assert property (p_od) else $error("reset pin driven high"); // RULE4
   c_wd: cover property (@(posedge CLK_SYS) disable iff (!RSTN) $fell(RESET_PIN_OE));
   c_trip: cover property (@(posedge CLK_SYS) disable iff (!RSTN) TRIP_IRQ);
   c_pc: cover property (@(posedge CLK_SYS) disable iff (!RSTN) PC_LOAD);
endmodule : rpt_top
`default_nettype wire

// ### design/rpt_defines.svh
// Constants for the reset and power-drive trip pin block.
`ifndef RPT_DEFINES_SVH
`define RPT_DEFINES_SVH
`define RPT_WD_RESET_CYCLES   8'd128
`define RPT_RESET_VECTOR      16'h0000
`define RPT_TRIP_MASK_BIT     0
`define RPT_CPU_CLOCK_OUT_SEL_BIT    7
`define RPT_TIMER2_PWM_OUT_SEL_BIT     8
`define RPT_MCR_RESET         16'h0000
`define RPT_IRQ_MASK_RESET    16'h0001
`endif

// ### design/rpt_pkg.sv
// Types shared by the reset and trip pin block.
`default_nettype none
package rpt_pkg;
   typedef enum logic [1:0] {RPT_RUN, RPT_WD_DRIVE} rpt_rst_state_type;
   typedef struct packed {
      logic [3:0] cmp_out;
      logic       t2_pwm;
      logic       cpu_clk;
   } rpt_func_type;
   typedef struct packed {
      logic [5:0] gpio_o;
      logic [5:0] gpio_oe;
   } rpt_gpio_type;
endpackage : rpt_pkg
`default_nettype wire

// ### design/rpt_sync.sv
// Two flip-flop synchroniser for pin inputs.
`default_nettype none
`include "rpt_defines.svh"
module rpt_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             clk,     // System clock.
   input  wire logic             rst_n,   // Asynchronous reset, active low.
   input  wire logic             ce,      // Clock enable.
   input  wire logic [WIDTH-1:0] d,       // Asynchronous inputs.
   output var  logic [WIDTH-1:0] q        // Synchronised outputs.
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } rpt_sync_state_type;
   rpt_sync_state_type st_q;
   rpt_sync_state_type st_d;
   // Pins idle high, so both stages reset to one.
   always_comb begin
      st_d = st_q;
      if (ce) begin
         st_d.s1 = d;
         st_d.s2 = st_q.s1;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '1;
      end else begin
         st_q <= st_d;
      end
   end
   assign q = st_q.s2;
endmodule : rpt_sync
`default_nettype wire

// ### testbench/rpt_far_side.sv
// Far side model: reset circuit, inverter trip stage and shared pin wires.
`default_nettype none
module rpt_far_side (
   input  wire logic       ext_rst_low, // External reset circuit pulls low.
   input  wire logic       rst_oe,      // Device reset pin enable.
   input  wire logic       rst_o,       // Device reset pin value.
   input  wire logic       fault,       // Inverter stage reports a fault.
   input  wire logic [5:0] pin_oe,      // Device shared pin enables.
   input  wire logic [5:0] pin_o,       // Device shared pin values.
   input  wire logic [5:0] ext_lvl,     // Outside levels on shared pins.
   output var  logic       rst_pin,     // Reset pin wire.
   output var  logic       trip_pin,    // Trip pin wire.
   output var  logic [5:0] pin_lvl      // Shared pin wires.
);
   timeunit 1ns;
   timeprecision 1ps;
   always_comb begin
      rst_pin = !(ext_rst_low || (rst_oe && !rst_o));
      trip_pin = !fault;
      for (int i = 0; i < 6; i++) begin
         pin_lvl[i] = pin_oe[i] ? pin_o[i] : ext_lvl[i];
      end
   end
endmodule : rpt_far_side
`default_nettype wire

// ### testbench/rpt_top_tb.sv
// Self-checking bench for the reset, trip and shared pin block.
`default_nettype none
module rpt_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 0, rstn = 0, wd_req = 0, ext_rst_low = 0, fault = 0, ce = 1;
   logic [15:0] irq_mask = 16'h0001, pin_ctrl = 16'h0000, pc_value;
   rpt_pkg::rpt_func_type func_in = '0;
   rpt_pkg::rpt_gpio_type gpio_in = '0;
   logic [3:0] cmp_sel = 4'h0;
   logic [5:0] ext_lvl = 6'h3f, pin_o, pin_oe, pin_i, eo, eoe, lvl;
   logic rst_o, rst_oe, halt, pc_load, trip_irq, e1, e2, adc, cap, rst_pin, trip_pin;
   int bad_count = 0, samples_checked = 0, cyc = 0, n;
   always #10 clk_sys = ~clk_sys;
   rpt_top uut (.CLK_SYS(clk_sys), .RSTN(rstn), .CE(ce), .RESET_PIN_N_I(rst_pin),
      .RESET_PIN_N_O(rst_o), .RESET_PIN_OE(rst_oe), .WD_RESET_REQ(wd_req), .CORE_HALT(halt),
      .PC_LOAD(pc_load), .PC_VALUE(pc_value), .TRIP_PIN_N_I(trip_pin),
      .IRQ_MASK_REG(irq_mask), .PIN_CTRL_REG(pin_ctrl), .TRIP_IRQ(trip_irq),
      .FUNC_IN(func_in), .GPIO_IN(gpio_in), .CMP_SEL(cmp_sel), .PIN_I(pin_i), .PIN_O(pin_o),
      .PIN_OE(pin_oe), .EXT_IRQ_1_IN(e1), .EXT_IRQ_2_IN(e2), .ADC_START_IN(adc),
      .CAPTURE_IN_1(cap));
   rpt_far_side far (.ext_rst_low(ext_rst_low), .rst_oe(rst_oe), .rst_o(rst_o),
      .fault(fault), .pin_oe(pin_oe), .pin_o(pin_o), .ext_lvl(ext_lvl), .rst_pin(rst_pin),
      .trip_pin(trip_pin), .pin_lvl(pin_i));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   // Waits a bounded time for the program counter load pulse and checks it.
   task automatic wait_load();
      n = 0;
      do begin
         @(posedge clk_sys);
         #1;
         n++;
      end while (pc_load !== 1'b1 && n < 300);
      chk(pc_load, 1'b1, "load pulse");
      chk(pc_value, 16'h0000, "load vector");
      chk(halt, 1'b0, "halt at load");
      @(posedge clk_sys);
      #1;
      chk(pc_load, 1'b0, "load pulse length");
      @(negedge clk_sys);
   endtask : wait_load
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         $display("[ERR] %0t timeout", $time);
         give_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h395c));
      repeat (3) @(negedge clk_sys);
      chk(halt, 1'b1, "halt in reset");
      rstn = 1;
      wait_load();
      $display("test reset release done");
      cmp_sel = 4'hf;
      pin_ctrl = 16'h0100;
      ext_rst_low = 1;
      repeat (6) @(negedge clk_sys);
      chk(halt, 1'b1, "pin reset halt");
      // The trip is held only a few cycles here; a wake from low power needs far longer.
      fault = 1;
      n = 0;
      while (trip_irq !== 1'b1 && n < 10) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk(trip_irq, 1'b1, "trip irq");
      repeat (4) @(negedge clk_sys);
      chk(pin_oe[4:0], 5'h00, "trip tristate halted");
      fault = 0;
      ext_rst_low = 0;
      wait_load();
      irq_mask = 16'h0000;
      fault = 1;
      repeat (8) begin
         @(posedge clk_sys);
         #1;
         chk(trip_irq, 1'b0, "masked irq");
      end
      chk(pin_oe[4:0], 5'h1f, "masked drive");
      @(negedge clk_sys);
      fault = 0;
      // Let the synchronised trip level clear before the mask enables the trip again.
      repeat (4) @(negedge clk_sys);
      irq_mask = 16'h0001;
      pin_ctrl = 16'h0000;
      repeat (4) begin
         @(posedge clk_sys);
         #1;
         chk(trip_irq, 1'b0, "no trip on unmask");
      end
      $display("test trip done");
      @(negedge clk_sys);
      wd_req = 1;
      @(negedge clk_sys);
      wd_req = 0;
      n = 0;
      while (rst_oe === 1'b1 && n < 400) begin
         chk(rst_o, 1'b0, "reset drive level");
         chk(halt, 1'b1, "watchdog halt");
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk(16'(n), 16'd128, "watchdog drive length");
      wait_load();
      $display("test watchdog done");
      repeat (24) begin
         cmp_sel = 4'($urandom());
         func_in = 6'($urandom());
         gpio_in = 12'($urandom());
         ext_lvl = 6'($urandom());
         pin_ctrl = {7'h00, 1'($urandom()), 1'($urandom()), 7'h00};
         for (int i = 0; i < 4; i++) begin
            eo[i] = cmp_sel[i] ? func_in.cmp_out[i] : gpio_in.gpio_o[i];
            eoe[i] = cmp_sel[i] | gpio_in.gpio_oe[i];
         end
         eo[4] = pin_ctrl[8] ? func_in.t2_pwm : gpio_in.gpio_o[4];
         eoe[4] = pin_ctrl[8] | gpio_in.gpio_oe[4];
         eo[5] = pin_ctrl[7] ? func_in.cpu_clk : gpio_in.gpio_o[5];
         eoe[5] = pin_ctrl[7] | gpio_in.gpio_oe[5];
         lvl = (eoe & eo) | (~eoe & ext_lvl);
         repeat (4) @(negedge clk_sys);
         chk(pin_o & eoe, eo & eoe, "pin value");
         chk(pin_oe, eoe, "pin enable");
         chk(e1, lvl[4], "irq one view");
         chk({e2, adc, cap}, {3{pin_ctrl[7] | lvl[5]}}, "clock pin views");
      end
      // With the clock enable low the pin drive must hold its last value.
      ce = 0;
      cmp_sel = ~cmp_sel;
      gpio_in = ~gpio_in;
      repeat (4) @(negedge clk_sys);
      chk(pin_oe, eoe, "frozen enable");
      chk(pin_o & eoe, eo & eoe, "frozen value");
      ce = 1;
      repeat (4) @(negedge clk_sys);
      $display("test pin sharing done");
      give_verdict();
   end
endmodule : rpt_top_tb
`default_nettype wire
